// >>> dv/fpn_nav_monitor.sv
// Checker of the level navigator outputs against its reset and software reset.
// Bound to the navigator top and sees only its ports.
`timescale 1ns/1ps
module fpn_nav_monitor #(
   parameter int TICK_CYCLES = 20
) (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_soft_reset,
   input wire logic [3:0] o_level,
   input wire logic o_commit,
   input wire logic o_lamp_test,
   input wire logic o_pv_flash,
   input wire logic o_control_stop
);
   logic [15:0] lamp_cnt;

   // Counts lamp test cycles; restarted by reset so one power-up is measured.
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         lamp_cnt <= 16'h0000;
      end else if (o_lamp_test) begin
         lamp_cnt <= lamp_cnt + 16'h0001;
      end
   end

   property p_reset;
      @(posedge i_core_clk) disable iff (i_rst)
      $fell(i_rst) |-> o_lamp_test && (o_level == 4'h9);
   endproperty
   a_reset: assert property (p_reset) else $error("reset state wrong");

   // The tick phase is unknown, so one tick of slack either way.
   property p_lamp_len;
      @(posedge i_core_clk) disable iff (i_rst)
      $fell(o_lamp_test) |-> (lamp_cnt > 16'(99 * TICK_CYCLES - 4)) && (lamp_cnt < 16'(101 * TICK_CYCLES + 4));
   endproperty
   a_lamp_len: assert property (p_lamp_len) else $error("lamp test length wrong");

   property p_lamp_exit;
      @(posedge i_core_clk) disable iff (i_rst)
      $fell(o_lamp_test) |-> ##[0:1] (o_level == 4'h0);
   endproperty
   a_lamp_exit: assert property (p_lamp_exit) else $error("lamp test not ending in operation");

   property p_calib;
      @(posedge i_core_clk) disable iff (i_rst)
      (o_level == 4'h8) && !i_soft_reset |=> (o_level == 4'h8);
   endproperty
   a_calib: assert property (p_calib) else $error("calibration left");

   property p_stop;
      @(posedge i_core_clk) disable iff (i_rst)
      (o_level inside {4'h5, 4'h6, 4'h7, 4'h8}) |-> ##[0:1] o_control_stop;
   endproperty
   a_stop: assert property (p_stop) else $error("control not stopped");

   property p_commit;
      @(posedge i_core_clk) disable iff (i_rst)
      o_commit |=> !o_commit;
   endproperty
   a_commit: assert property (p_commit) else $error("commit longer than one cycle");

   property p_flash;
      @(posedge i_core_clk) disable iff (i_rst)
      o_pv_flash |-> ($past(o_level) inside {4'h0, 4'h1});
   endproperty
   a_flash: assert property (p_flash) else $error("flash outside operation or adjustment");

   property p_soft;
      @(posedge i_core_clk) disable iff (i_rst)
      i_soft_reset && !(o_level inside {4'h8, 4'h9}) |-> ##[1:2] (o_level == 4'h0);
   endproperty
   a_soft: assert property (p_soft) else $error("soft reset missed");
endmodule

// >>> dv/fpn_operator.sv
// Operator model pressing the front panel keys.
// Assumes the navigator core clock; keys are plain high-active switches.
`timescale 1ns/1ps
module fpn_operator #(
   parameter int TICK_CYCLES = 20
) (
   input wire logic i_core_clk,
   output logic [4:0] o_keys
);
   initial o_keys = 5'h00;

   // Holds a key set for some ticks, then lets go and waits for the filter to settle.
   task automatic hold(input logic [4:0] keys, input int ticks);
      @(negedge i_core_clk);
      o_keys = keys;
      repeat (ticks * TICK_CYCLES) @(negedge i_core_clk);
      o_keys = 5'h00;
      repeat (6 * TICK_CYCLES) @(negedge i_core_clk);
   endtask
endmodule

// >>> dv/front_panel_level_navigator_tb.sv
// Self-checking bench of the front panel level navigator.
// Settings change at the falling edge; the operator model presses keys.
`timescale 1ns/1ps
module front_panel_level_navigator_tb;
   localparam int TICKS = 20;
   localparam logic [4:0] LVL = 5'h01, PRM = 5'h02, UPK = 5'h04, DNK = 5'h08, FNC = 5'h10;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic soft_reset = 1'b0;
   logic [4:0] keys;
   logic [3:0] hold_sec = 4'h2;
   logic [8:0] hidden = 9'h000;
   logic [1:0] fkey_mode = 2'h0;
   logic [1:0] protect = 2'h1;
   logic [15:0] param_value = 16'hff58;
   logic [3:0] level;
   logic [3:0] param_index;
   logic [15:0] edit_value;
   logic commit, lamp_test, pv_flash, control_stop;
   int n_fail = 0;
   int total_checks = 0;
   int n_commit = 0;
   int cycles = 0;

   always #2.5 clk = ~clk;

   fpn_operator #(.TICK_CYCLES(TICKS)) op (.i_core_clk(clk), .o_keys(keys));

   fpn_navigator #(.TICK_CYCLES(TICKS), .VALUE_W(16)) i_dut (
      .i_core_clk(clk), .i_rst(rst), .i_soft_reset(soft_reset),
      .i_key_level(keys[0]), .i_key_mode(keys[1]), .i_key_up(keys[2]),
      .i_key_down(keys[3]), .i_key_function(keys[4]),
      .i_protect_hold_sec(hold_sec), .i_level_hidden(hidden),
      .i_function_key_mode(fkey_mode), .i_init_comm_protect(protect),
      .i_param_last(4'h2), .i_param_value(param_value),
      .o_level(level), .o_param_index(param_index), .o_edit_value(edit_value),
      .o_commit(commit), .o_lamp_test(lamp_test), .o_pv_flash(pv_flash),
      .o_control_stop(control_stop)
   );

   // Counts commit pulses and cuts a hang short well past the expected run.
   always @(negedge clk) begin
      cycles++;
      if (commit === 1'b1) n_commit++;
      if (cycles == 80000) begin
         n_fail++;
         finish_test();
      end
   end

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wait_ticks(input int n);
      repeat (n * TICKS) @(negedge clk);
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // Main sequence: each test is a run of key gestures with expected levels.
   initial begin
      repeat (5) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      check("lamp", lamp_test, 16'h1);
      wait_ticks(110);
      check("lamp", lamp_test, 16'h0);
      check("level", level, 16'h0);
      check("stop", control_stop, 16'h0);
      $display("test power_up done");
      op.hold(LVL, 20);
      check("level", level, 16'h1);
      op.hold(LVL, 20);
      check("level", level, 16'h0);
      hidden = 9'h002;
      op.hold(LVL, 20);
      check("level", level, 16'h0);
      hidden = 9'h000;
      for (int i = 1; i <= 3; i++) begin
         op.hold(PRM, 20);
         check("param", param_index, 16'(i % 3));
      end
      op.hold(DNK | PRM, 20);
      check("param", param_index, 16'h2);
      // A two second setting must refuse a chord of just over one second.
      op.hold(LVL | PRM, 130);
      check("level", level, 16'h0);
      hold_sec = 4'h1;
      op.hold(LVL | PRM, 130);
      check("level", level, 16'h2);
      op.hold(LVL | PRM, 130);
      check("level", level, 16'h0);
      $display("test short_and_chord done");
      fkey_mode = 2'h2;
      op.hold(FNC, 20);
      check("level", level, 16'h4);
      op.hold(FNC, 20);
      check("level", level, 16'h0);
      fkey_mode = 2'h1;
      op.hold(FNC, 130);
      check("level", level, 16'h3);
      op.hold(LVL, 130);
      check("level", level, 16'h0);
      op.hold(PRM, 20);
      check("param", param_index, 16'h1);
      op.hold(LVL, 330);
      check("level", level, 16'h3);
      op.hold(FNC, 130);
      check("level", level, 16'h0);
      $display("test function_key done");
      fork
         op.hold(LVL, 330);
         begin
            wait_ticks(200);
            check("flash", pv_flash, 16'h1);
         end
      join
      check("level", level, 16'h5);
      check("stop", control_stop, 16'h1);
      op.hold(LVL, 20);
      check("level", level, 16'h6);
      op.hold(LVL, 20);
      check("level", level, 16'h5);
      // The password only opens the advanced level with the protect setting at zero.
      for (int p = 1; p >= 0; p--) begin
         protect = 2'(p);
         op.hold(DNK, 20);
         check("edit", edit_value, 16'hff57);
         op.hold(PRM, 20);
         check("level", level, (p == 1) ? 16'h5 : 16'h7);
      end
      check("commits", 16'(n_commit), 16'h2);
      param_value = 16'h04b0;
      op.hold(UPK, 20);
      wait_ticks(150);
      check("level", level, 16'h7);
      wait_ticks(60);
      check("level", level, 16'h8);
      check("commits", 16'(n_commit), 16'h3);
      op.hold(DNK | PRM, 20);
      check("param", param_index, 16'h0);
      op.hold(LVL, 130);
      check("level", level, 16'h8);
      $display("test passwords done");
      rst = 1'b1;
      repeat (5) @(negedge clk);
      rst = 1'b0;
      wait_ticks(110);
      check("level", level, 16'h0);
      op.hold(LVL, 20);
      check("level", level, 16'h1);
      soft_reset = 1'b1;
      @(negedge clk);
      soft_reset = 1'b0;
      repeat (2) @(negedge clk);
      check("level", level, 16'h0);
      $display("test resets done");
      finish_test();
   end
endmodule

bind fpn_navigator fpn_nav_monitor #(
   .TICK_CYCLES(TICK_CYCLES)
) i_mon (
   .i_core_clk(i_core_clk),
   .i_rst(i_rst),
   .i_soft_reset(i_soft_reset),
   .o_level(o_level),
   .o_commit(o_commit),
   .o_lamp_test(o_lamp_test),
   .o_pv_flash(o_pv_flash),
   .o_control_stop(o_control_stop)
);

// >>> logic/fpn_key_filter.sv
// Synchronises, debounces and times the front panel keys.
// Assumes active-high key pins from outside the clock domain.
`timescale 1ns/1ps
module fpn_key_filter (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic [fpn_pkg::NUM_KEYS-1:0] i_keys,
   fpn_keys_if.filter keys
);
   genvar k;
   for (k = 0; k < fpn_pkg::NUM_KEYS; k++) begin : g_key
      logic [1:0] sync_q;
      logic [1:0] same;
      logic deb;
      logic deb_q;
      logic [fpn_pkg::CNT_W-1:0] cnt;
      wire differs = sync_q[1] != deb;

      // A level change must hold for two ticks, so contact bounce never toggles deb.
      always_ff @(posedge i_core_clk) begin
         if (i_rst) begin
            sync_q <= 2'h0;
            same <= 2'h0;
            deb <= 1'b0;
            deb_q <= 1'b0;
            cnt <= '0;
         end else begin
            sync_q <= {sync_q[0], i_keys[k]};
            deb_q <= deb;
            if (!differs) begin
               same <= 2'h0;
            end else if (keys.tick) begin
               same <= (same == fpn_pkg::DEBOUNCE_TICKS - 2'h1) ? 2'h0 : same + 2'h1;
               if (same == fpn_pkg::DEBOUNCE_TICKS - 2'h1) deb <= sync_q[1];
            end
            if (!deb) begin
               cnt <= '0;
            end else if (keys.tick && cnt != fpn_pkg::CNT_MAX) begin
               cnt <= cnt + 1'b1;
            end
         end
      end

      // The count is still valid in the cycle the release pulse shows.
      assign keys.down[k] = deb;
      assign keys.rise[k] = deb & ~deb_q; // R23
      assign keys.fall[k] = deb_q & ~deb;
      assign keys.held[k] = cnt; // R23
   end
endmodule

// >>> logic/fpn_keys_if.sv
// Key status bundle between the tick generator, key filter and navigator.
// All signals live in the core clock domain.
`timescale 1ns/1ps
interface fpn_keys_if;
   logic tick;
   logic [fpn_pkg::NUM_KEYS-1:0] down;
   logic [fpn_pkg::NUM_KEYS-1:0] rise;
   logic [fpn_pkg::NUM_KEYS-1:0] fall;
   logic [fpn_pkg::CNT_W-1:0] held [fpn_pkg::NUM_KEYS];

   modport timer (output tick);
   modport filter (input tick, output down, rise, fall, held);
   modport nav (input tick, down, rise, fall, held);
endinterface

// >>> logic/fpn_navigator.sv
// Front panel level navigator: tracks the active parameter level and parameter,
// times key holds, checks passwords and commits edited values.
// Assumes key pins from outside the clock domain and settings from core logic.
// Functional notes
// R1 - After reset all segments light for one second before normal display.
// R2 - Lamp test ends in operation level; protect, initial and adjustment reachable.
// R3 - Level and parameter keys held together enter protect level.
// R4 - The protect hold time comes from a programmable setting.
// R5 - Hidden levels are never entered from the panel.
// R6 - Short level key press in operation moves to adjustment.
// R7 - Adjustment leads to initial top parameter, protect or operation.
// R8 - Function key opens monitor level; it exits to operation or initial.
// R9 - Function key held over one second under auto/manual enters manual.
// R10 - Manual exits only to operation, by level or function key hold.
// R11 - Level key held 3 s enters initial; display flashes after 1 s.
// R12 - Short level key press in initial moves to communications level.
// R13 - The 3 s hold on auto/manual display enters manual instead.
// R14 - Initial, communications, advanced and calibration levels halt control outputs.
// R15 - Advanced level needs protect value 0 and password -169.
// R16 - Advanced level leads to calibration or back to initial.
// R17 - Password 1201 in advanced level enters calibration.
// R18 - Calibration is left only through power cycle reset; the code also leaves it to operation on software reset.
// R19 - Software reset returns to operation level from anywhere; the code ignores it during lamp test.
// R20 - Parameter key steps forward or backward; no backward in calibration.
// R21 - Stepping past the last parameter wraps to the first.
// R22 - Edits commit after two idle seconds or on parameter key press.
// R23 - Keys are debounced and timed with a 10 ms tick.
`timescale 1ns/1ps
module fpn_navigator #(
   parameter int TICK_CYCLES = fpn_pkg::TICK_CYCLES,
   parameter int VALUE_W = 16
) (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_soft_reset,
   input wire logic i_key_level,
   input wire logic i_key_mode,
   input wire logic i_key_up,
   input wire logic i_key_down,
   input wire logic i_key_function,
   input wire logic [3:0] i_protect_hold_sec,
   input wire logic [8:0] i_level_hidden,
   input wire logic [1:0] i_function_key_mode,
   input wire logic [1:0] i_init_comm_protect,
   input wire logic [3:0] i_param_last,
   input wire logic [VALUE_W-1:0] i_param_value,
   output logic [3:0] o_level,
   output logic [3:0] o_param_index,
   output logic [VALUE_W-1:0] o_edit_value,
   output logic o_commit,
   output logic o_lamp_test,
   output logic o_pv_flash,
   output logic o_control_stop
);
   // Key positions in the key vectors.
   localparam int L = fpn_pkg::KEY_LEVEL;
   localparam int M = fpn_pkg::KEY_MODE;
   localparam int U = fpn_pkg::KEY_UP;
   localparam int D = fpn_pkg::KEY_DOWN;
   localparam int F = fpn_pkg::KEY_FUNC;
   localparam logic [fpn_pkg::CNT_W-1:0] ONE_TICK = 11'h001;

   fpn_keys_if keys ();

   // Level and parameter state.
   fpn_pkg::fpn_level_e level;
   fpn_pkg::fpn_level_e want;
   fpn_pkg::fpn_level_e next_level;
   logic [3:0] param;
   logic [3:0] next_param;

   // Lamp, chord and pause timers in ticks.
   logic [fpn_pkg::CNT_W-1:0] lamp_cnt;
   logic [fpn_pkg::CNT_W-1:0] combo_cnt;
   logic [fpn_pkg::CNT_W-1:0] pause_cnt;

   // Pending edit.
   logic [VALUE_W-1:0] edit;
   logic [VALUE_W-1:0] next_edit;
   logic dirty;
   logic next_dirty;

   // True on the tick at which a hold counter reaches n ticks; fires once per hold.
   function automatic logic reach(input logic tick, input logic [fpn_pkg::CNT_W-1:0] c,
                                  input logic [fpn_pkg::CNT_W-1:0] n);
      reach = tick && n != '0 && c == n - ONE_TICK;
   endfunction

   fpn_tick_gen #(
      .TICK_CYCLES(TICK_CYCLES)
   ) u_tick (
      .i_core_clk(i_core_clk),
      .i_rst(i_rst),
      .keys(keys)
   );

   fpn_key_filter u_filter (
      .i_core_clk(i_core_clk),
      .i_rst(i_rst),
      .i_keys({i_key_function, i_key_down, i_key_up, i_key_mode, i_key_level}),
      .keys(keys)
   );

   // The protect hold is programmable in whole seconds; zero is read as one second.
   wire [3:0] prot_sec = (i_protect_hold_sec == 4'h0) ? 4'h1 : i_protect_hold_sec;
   wire [fpn_pkg::CNT_W-1:0] prot_ticks = fpn_pkg::CNT_W'(prot_sec * fpn_pkg::TICKS_PER_SEC); // R4
   wire combo_down = keys.down[L] & keys.down[M];

   // Key gesture decode; holds are seen while the key is still down.
   wire lvl_short = keys.fall[L] && keys.held[L] < fpn_pkg::SHORT_TICKS;
   wire lvl_1s = keys.down[L] && reach(keys.tick, keys.held[L], fpn_pkg::SHORT_TICKS);
   wire lvl_3s = keys.down[L] && reach(keys.tick, keys.held[L], fpn_pkg::INIT_TICKS);

   // Function key role.
   wire fn_am = i_function_key_mode == fpn_pkg::FPN_FKEY_AUTO_MANUAL;
   wire fn_mon = i_function_key_mode == fpn_pkg::FPN_FKEY_MONITOR_SELECT;
   wire fn_long = fn_am && keys.down[F] && reach(keys.tick, keys.held[F], fpn_pkg::SHORT_TICKS + ONE_TICK);
   wire fn_press = fn_mon && keys.rise[F];

   // Chord and lamp timer thresholds.
   wire combo_hit = combo_down && reach(keys.tick, combo_cnt, prot_ticks); // R3
   wire lamp_done = reach(keys.tick, lamp_cnt, fpn_pkg::LAMP_TICKS);
   wire op_or_adj = level == fpn_pkg::FPN_OPERATION || level == fpn_pkg::FPN_ADJUSTMENT;
   wire on_am_display = level == fpn_pkg::FPN_OPERATION && param == fpn_pkg::OP_AUTO_MANUAL_PARAM;

   // The parameter key alone is ignored while it forms part of the protect chord.
   wire mode_press = keys.rise[M] && !keys.down[L];
   wire back_press = mode_press && keys.down[D] && level != fpn_pkg::FPN_CALIBRATION; // R20
   wire fwd_press = mode_press && !keys.down[D]; // R20
   wire up_press = keys.rise[U] && !keys.down[M];
   wire dn_press = keys.rise[D] && !keys.down[M];

   // A pending edit commits on two idle seconds or on the parameter key.
   wire pause_done = dirty && reach(keys.tick, pause_cnt, fpn_pkg::COMMIT_TICKS);
   wire commit_now = dirty && (pause_done || mode_press); // R22
   wire pw_adv = commit_now && level == fpn_pkg::FPN_INITIAL && edit == fpn_pkg::PW_ADVANCED
                 && i_init_comm_protect == fpn_pkg::PROTECT_OPEN; // R15
   wire pw_cal = commit_now && level == fpn_pkg::FPN_ADVANCED && edit == fpn_pkg::PW_CALIBRATION; // R17

   // Level moves requested by the gestures of the current level.
   always_comb begin
      want = level;
      unique case (level)
         // Lamp test after power-up.
         fpn_pkg::FPN_LAMP_TEST: begin
            if (lamp_done) want = fpn_pkg::FPN_OPERATION; // R2
         end

         // The chord outranks single keys.
         fpn_pkg::FPN_OPERATION, fpn_pkg::FPN_ADJUSTMENT: begin
            if (combo_hit) begin
               want = fpn_pkg::FPN_PROTECT; // R3
            end else if (lvl_3s && on_am_display) begin
               want = fpn_pkg::FPN_MANUAL; // R13
            end else if (lvl_3s) begin
               want = fpn_pkg::FPN_INITIAL; // R11
            end else if (fn_long) begin
               want = fpn_pkg::FPN_MANUAL; // R9
            end else if (fn_press) begin
               want = fpn_pkg::FPN_MONITOR; // R8
            end else if (lvl_short && level == fpn_pkg::FPN_OPERATION) begin
               want = fpn_pkg::FPN_ADJUSTMENT; // R6
            end else if (lvl_short) begin
               want = fpn_pkg::FPN_OPERATION; // R7
            end
         end

         // Monitor item display.
         fpn_pkg::FPN_MONITOR: begin
            if (combo_hit) begin
               want = fpn_pkg::FPN_PROTECT; // R3
            end else if (lvl_3s) begin
               want = fpn_pkg::FPN_INITIAL; // R8
            end else if (fn_press) begin
               want = fpn_pkg::FPN_OPERATION; // R8
            end
         end

         // The chord toggles protect.
         fpn_pkg::FPN_PROTECT: begin
            if (combo_hit) want = fpn_pkg::FPN_OPERATION;
         end

         // Manual exits to operation only.
         fpn_pkg::FPN_MANUAL: begin
            if (lvl_1s || fn_long) want = fpn_pkg::FPN_OPERATION; // R10
         end

         // Password first, then level key.
         fpn_pkg::FPN_INITIAL: begin
            if (pw_adv) begin
               want = fpn_pkg::FPN_ADVANCED; // R15
            end else if (lvl_1s) begin
               want = fpn_pkg::FPN_OPERATION; // R11
            end else if (lvl_short) begin
               want = fpn_pkg::FPN_COMMS; // R12
            end
         end

         // Communications settings.
         fpn_pkg::FPN_COMMS: begin
            if (lvl_1s) begin
               want = fpn_pkg::FPN_OPERATION;
            end else if (lvl_short) begin
               want = fpn_pkg::FPN_INITIAL;
            end
         end

         // Advanced functions.
         fpn_pkg::FPN_ADVANCED: begin
            if (pw_cal) begin
               want = fpn_pkg::FPN_CALIBRATION; // R17
            end else if (lvl_1s) begin
               want = fpn_pkg::FPN_INITIAL; // R16
            end
         end

         // Calibration has no key exit.
         fpn_pkg::FPN_CALIBRATION: begin
            want = fpn_pkg::FPN_CALIBRATION; // R18
         end

         // Illegal codes recover.
         default: begin
            want = fpn_pkg::FPN_OPERATION;
         end
      endcase
   end

   // A hidden target cancels the move; the operation level is never hidden.
   wire [9:0] hidden = {1'b0, i_level_hidden};
   wire blocked = want != fpn_pkg::FPN_OPERATION && hidden[want]; // R5
   wire moving = want != level && !blocked;
   wire soft_move = i_soft_reset && level != fpn_pkg::FPN_LAMP_TEST;
   wire level_change = soft_move || moving;

   // Software reset outranks any key move.
   always_comb begin
      if (soft_move) begin
         next_level = fpn_pkg::FPN_OPERATION; // R19
      end else if (moving) begin
         next_level = want;
      end else begin
         next_level = level;
      end
   end

   // Every level is entered at its top parameter; the last one wraps to the top.
   wire at_last = param >= i_param_last;
   wire [3:0] fwd_param = at_last ? fpn_pkg::PARAM_TOP : param + 4'h1; // R21
   wire [3:0] back_param = (param == fpn_pkg::PARAM_TOP) ? i_param_last : param - 4'h1;

   always_comb begin
      if (level_change || level == fpn_pkg::FPN_LAMP_TEST) begin
         next_param = fpn_pkg::PARAM_TOP; // R7
      end else if (back_press) begin
         next_param = back_param; // R20
      end else if (fwd_press) begin
         next_param = fwd_param; // R20
      end else begin
         next_param = param;
      end
   end

   // The edit value tracks the stored value until an up or down press makes it dirty.
   // A level change drops an uncommitted edit, keeping the value held before it.
   always_comb begin
      next_edit = edit;
      next_dirty = dirty;
      if (level_change || commit_now || level == fpn_pkg::FPN_LAMP_TEST) begin
         next_dirty = 1'b0; // R22
      end else if (up_press) begin
         next_edit = edit + VALUE_W'(fpn_pkg::EDIT_STEP);
         next_dirty = 1'b1;
      end else if (dn_press) begin
         next_edit = edit - VALUE_W'(fpn_pkg::EDIT_STEP);
         next_dirty = 1'b1;
      end else if (!dirty) begin
         next_edit = i_param_value;
      end
   end

   // Level, parameter and edit state.
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         level <= fpn_pkg::FPN_LAMP_TEST; // R1
         param <= fpn_pkg::PARAM_TOP;
         edit <= '0;
         dirty <= 1'b0;
      end else begin
         level <= next_level; // R19
         param <= next_param;
         edit <= next_edit;
         dirty <= next_dirty;
      end
   end

   // Timers count ticks; the chord and pause timers restart whenever their condition lapses, the lamp timer only on reset.
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         lamp_cnt <= '0;
         combo_cnt <= '0;
         pause_cnt <= '0;
      end else begin
         if (level == fpn_pkg::FPN_LAMP_TEST && keys.tick && lamp_cnt != fpn_pkg::CNT_MAX) begin
            lamp_cnt <= lamp_cnt + 1'b1; // R1
         end
         if (!combo_down) begin
            combo_cnt <= '0;
         end else if (keys.tick && combo_cnt != fpn_pkg::CNT_MAX) begin
            combo_cnt <= combo_cnt + 1'b1; // R3
         end
         if (!dirty || up_press || dn_press) begin
            pause_cnt <= '0;
         end else if (keys.tick && pause_cnt != fpn_pkg::CNT_MAX) begin
            pause_cnt <= pause_cnt + 1'b1; // R22
         end
      end
   end

   // Stopped-control levels, decoded once for the registered output.
   wire stop_level = next_level == fpn_pkg::FPN_INITIAL || next_level == fpn_pkg::FPN_COMMS
                     || next_level == fpn_pkg::FPN_ADVANCED || next_level == fpn_pkg::FPN_CALIBRATION;
   wire flash = op_or_adj && keys.down[L] && keys.held[L] >= fpn_pkg::SHORT_TICKS;

   // Outputs are registered so the panel sees no decode glitches.
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         o_lamp_test <= 1'b1;
         o_control_stop <= 1'b0;
         o_pv_flash <= 1'b0;
         o_commit <= 1'b0;
      end else begin
         o_lamp_test <= next_level == fpn_pkg::FPN_LAMP_TEST; // R1
         o_control_stop <= stop_level; // R14
         o_pv_flash <= flash && !level_change; // R11
         o_commit <= commit_now; // R22
      end
   end

   // Outputs taken straight from state flops.
   assign o_level = level;
   assign o_param_index = param;
   assign o_edit_value = edit;
endmodule

// >>> logic/fpn_pkg.sv
// Shared constants and types of the front panel level navigator.
// Assumes a 200 MHz core clock and a 10 ms key sampling tick.
package fpn_pkg;
   // Clock and tick timing.
   localparam int CLK_PERIOD_NS = 5;
   localparam int TICK_PERIOD_MS = 10;
   localparam int NS_PER_MS = 1000000;
   localparam int MS_PER_SEC = 1000;
   localparam int TICK_CYCLES = TICK_PERIOD_MS * NS_PER_MS / CLK_PERIOD_NS;
   localparam int TICK_CNT_W = 21;

   // Key indices inside the key vector.
   localparam int NUM_KEYS = 5;
   localparam int KEY_LEVEL = 0;
   localparam int KEY_MODE = 1;
   localparam int KEY_UP = 2;
   localparam int KEY_DOWN = 3;
   localparam int KEY_FUNC = 4;

   // Hold counters count ticks and saturate.
   localparam int CNT_W = 11;
   localparam logic [CNT_W-1:0] CNT_MAX = 11'h7ff;
   localparam logic [1:0] DEBOUNCE_TICKS = 2'h2;

   // Times in seconds and their tick counts.
   localparam int LAMP_TEST_S = 1;
   localparam int HOLD_SHORT_S = 1;
   localparam int HOLD_INIT_S = 3;
   localparam int COMMIT_PAUSE_S = 2;
   localparam logic [CNT_W-1:0] TICKS_PER_SEC = CNT_W'(MS_PER_SEC / TICK_PERIOD_MS);
   localparam logic [CNT_W-1:0] LAMP_TICKS = CNT_W'(LAMP_TEST_S * MS_PER_SEC / TICK_PERIOD_MS);
   localparam logic [CNT_W-1:0] SHORT_TICKS = CNT_W'(HOLD_SHORT_S * MS_PER_SEC / TICK_PERIOD_MS);
   localparam logic [CNT_W-1:0] INIT_TICKS = CNT_W'(HOLD_INIT_S * MS_PER_SEC / TICK_PERIOD_MS);
   localparam logic [CNT_W-1:0] COMMIT_TICKS = CNT_W'(COMMIT_PAUSE_S * MS_PER_SEC / TICK_PERIOD_MS);

   // Passwords, protect value and special parameter positions.
   localparam logic [15:0] PW_ADVANCED = 16'hff57;
   localparam logic [15:0] PW_CALIBRATION = 16'h04b1;
   localparam logic [1:0] PROTECT_OPEN = 2'h0;
   localparam logic [3:0] PARAM_TOP = 4'h0;
   localparam logic [3:0] OP_AUTO_MANUAL_PARAM = 4'h1;
   localparam logic [15:0] EDIT_STEP = 16'h0001;

   // Parameter levels; the lamp test state precedes them all.
   typedef enum logic [3:0] {
      FPN_OPERATION = 4'b0000,
      FPN_ADJUSTMENT = 4'b0001,
      FPN_PROTECT = 4'b0010,
      FPN_MANUAL = 4'b0011,
      FPN_MONITOR = 4'b0100,
      FPN_INITIAL = 4'b0101,
      FPN_COMMS = 4'b0110,
      FPN_ADVANCED = 4'b0111,
      FPN_CALIBRATION = 4'b1000,
      FPN_LAMP_TEST = 4'b1001
   } fpn_level_e;

   // Function key setting.
   typedef enum logic [1:0] {
      FPN_FKEY_NONE = 2'b00,
      FPN_FKEY_AUTO_MANUAL = 2'b01,
      FPN_FKEY_MONITOR_SELECT = 2'b10
   } fpn_fkey_e;
endpackage

// >>> logic/fpn_tick_gen.sv
// Free-running divider that makes the 10 ms key sampling tick.
// Assumes a synchronous active-high reset on the core clock.
`timescale 1ns/1ps
module fpn_tick_gen #(
   parameter int TICK_CYCLES = fpn_pkg::TICK_CYCLES
) (
   input wire logic i_core_clk,
   input wire logic i_rst,
   fpn_keys_if.timer keys
);
   logic [fpn_pkg::TICK_CNT_W-1:0] count;
   logic tick;
   wire last = count == fpn_pkg::TICK_CNT_W'(TICK_CYCLES - 1);

   // The divider never stops, so hold times are measured against a steady base.
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         count <= '0;
         tick <= 1'b0;
      end else begin
         count <= last ? '0 : count + 1'b1;
         tick <= last;
      end
   end

   assign keys.tick = tick;
endmodule
